// >>> rtl/uppt_manager.sv
// boot-side walker of the update pointer block
// assumes a same-clock flash word reader and image loader handshake
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module uppt_manager
  import uppt_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic flash_req_out,
  output logic [31:0] flash_addr_out,
  input wire logic flash_ack_in,
  input wire logic [31:0] flash_data_in,
  output logic load_req_out,
  output logic [63:0] load_addr_out,
  input wire logic load_done_in,
  input wire logic load_ok_in,
  output logic fallback_out,
  output logic busy_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state and storage

  uppt_state_t state;
  logic phase;
  logic use_backup;
  logic [31:0] pt_base;
  logic [6:0] desc_idx;
  logic [31:0] cpb_base;
  logic [31:0] slot_off;
  logic [8:0] slot;
  logic [15:0] tries;
  logic done_flag;
  logic pt_bad;
  logic cpb_bad_a;
  logic cpb_bad_b;
  logic [2:0] wcnt;
  logic [5:0][31:0] words;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  logic wr_ctrl;
  logic start;
  logic active;
  logic launch;
  logic fetched;
  logic [31:0] fetch_base;
  logic [2:0] fetch_n;
  logic [6:0] sel_idx;
  logic [31:0] desc_addr;
  logic [31:0] desc_flags;
  logic desc_ok;
  logic pt_ok;
  logic cpb_ok;
  logic slot_valid;
  logic [31:0] slot_cnt_m1;
  logic last_slot;

  assign wr_ctrl = reg_wr_in && (reg_addr_in == UPPT_REG_CTRL);
  assign active = (state != UPPT_IDLE) && (state != UPPT_DONE) && (state != UPPT_FALLBACK);
  assign start = wr_ctrl && reg_wdata_in[0] && !active;
  assign launch = !phase && ((state == UPPT_PT_HDR) || (state == UPPT_DESC)
    || (state == UPPT_CPB_HDR) || (state == UPPT_SLOT));
  assign fetched = phase && !flash_req_out;

  // backup copy has the descriptor after the primary
  assign sel_idx = desc_idx + {6'h00, use_backup};
  assign desc_addr = pt_base + UPPT_PT_DESC0 + ({25'h0000000, sel_idx} << UPPT_DESC_SHIFT)
    + UPPT_DESC_START;
  assign desc_flags = words[3];
  assign desc_ok = desc_flags[UPPT_FLAG_SYSTEM] && !desc_flags[UPPT_FLAG_RDONLY];

  assign fetch_base = (state == UPPT_PT_HDR) ? pt_base
    : (state == UPPT_DESC) ? desc_addr
    : (state == UPPT_CPB_HDR) ? cpb_base
    : cpb_base + slot_off + ({23'h000000, slot} << UPPT_SLOT_SHIFT);
  assign fetch_n = (state == UPPT_PT_HDR) ? UPPT_N_PT
    : (state == UPPT_DESC) ? UPPT_N_DESC
    : (state == UPPT_CPB_HDR) ? UPPT_N_CPB
    : UPPT_N_SLOT;

  assign slot_cnt_m1 = words[5] - 32'h1;
  assign last_slot = (slot == 9'h000);

  ////////////////////////////////////////////////////////////////////////////
  // checkers

  uppt_hdr_check u_hdr (
    .words_in(words),
    .desc_idx_in(desc_idx),
    .pt_ok_out(pt_ok),
    .cpb_ok_out(cpb_ok)
  );

  uppt_slot_class u_slot (
    .slot_in({words[1], words[0]}),
    .unused_out(),
    .cancelled_out(),
    .valid_out(slot_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // flash word fetch

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      flash_req_out <= 1'b0;
      flash_addr_out <= 32'h00000000;
      wcnt <= 3'h0;
      words <= '0;
    end
    else if (launch)
    begin
      flash_req_out <= 1'b1;
      flash_addr_out <= fetch_base;
      wcnt <= 3'h0;
    end
    else if (flash_req_out && flash_ack_in)
    begin
      words[wcnt] <= flash_data_in;
      flash_addr_out <= flash_addr_out + 32'h4;
      wcnt <= wcnt + 3'h1;
      if (wcnt == fetch_n - 3'h1)
      begin
        flash_req_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // walk sequence

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state <= UPPT_IDLE;
      phase <= 1'b0;
      use_backup <= 1'b0;
      cpb_base <= 32'h00000000;
      slot_off <= 32'h00000000;
      slot <= 9'h000;
      tries <= 16'h0000;
      pt_bad <= 1'b0;
      cpb_bad_a <= 1'b0;
      cpb_bad_b <= 1'b0;
      load_req_out <= 1'b0;
      load_addr_out <= 64'h0000000000000000;
      fallback_out <= 1'b0;
    end
    else if (start)
    begin
      state <= UPPT_PT_HDR;
      phase <= 1'b0;
      use_backup <= 1'b0;
      tries <= 16'h0000;
      pt_bad <= 1'b0;
      cpb_bad_a <= 1'b0;
      cpb_bad_b <= 1'b0;
      fallback_out <= 1'b0;
    end
    else
    begin
      if (launch)
      begin
        phase <= 1'b1;
      end
      unique case (state)
        UPPT_IDLE, UPPT_DONE:
        begin
        end
        UPPT_FALLBACK:
        begin
          fallback_out <= 1'b1;
        end
        UPPT_PT_HDR:
        begin
          if (fetched)
          begin
            phase <= 1'b0;
            pt_bad <= !pt_ok;
            state <= pt_ok ? UPPT_DESC : UPPT_FALLBACK;
          end
        end
        UPPT_DESC:
        begin
          if (fetched)
          begin
            phase <= 1'b0;
            cpb_base <= words[0];
            if (desc_ok)
            begin
              state <= UPPT_CPB_HDR;
            end
            else if (!use_backup)
            begin
              cpb_bad_a <= 1'b1;
              use_backup <= 1'b1;
            end
            else
            begin
              cpb_bad_b <= 1'b1;
              state <= UPPT_FALLBACK;
            end
          end
        end
        UPPT_CPB_HDR:
        begin
          if (fetched)
          begin
            phase <= 1'b0;
            slot_off <= words[4];
            slot <= slot_cnt_m1[8:0];
            if (cpb_ok && (words[5] != 32'h0))
            begin
              state <= UPPT_SLOT;
            end
            else if (!use_backup)
            begin
              cpb_bad_a <= !cpb_ok;
              use_backup <= !cpb_ok;
              state <= cpb_ok ? UPPT_FALLBACK : UPPT_DESC;
            end
            else
            begin
              cpb_bad_b <= !cpb_ok;
              state <= UPPT_FALLBACK;
            end
          end
        end
        UPPT_SLOT:
        begin
          if (fetched)
          begin
            phase <= 1'b0;
            if (slot_valid)
            begin
              load_addr_out <= {words[1], words[0]};
              load_req_out <= 1'b1;
              tries <= tries + 16'h1;
              state <= UPPT_LOAD;
            end
            else if (last_slot)
            begin
              state <= UPPT_FALLBACK;
            end
            else
            begin
              slot <= slot - 9'h1;
            end
          end
        end
        UPPT_LOAD:
        begin
          if (load_done_in)
          begin
            load_req_out <= 1'b0;
            if (load_ok_in)
            begin
              state <= UPPT_DONE;
            end
            else if (last_slot)
            begin
              state <= UPPT_FALLBACK;
            end
            else
            begin
              slot <= slot - 9'h1;
              state <= UPPT_SLOT;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [31:0] status_word;
  logic [31:0] rd_mux;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pt_base <= UPPT_PT_BASE_RST;
      desc_idx <= UPPT_DESC_IDX_RST;
    end
    else if (reg_wr_in && !active)
    begin
      if (reg_addr_in == UPPT_REG_PT_BASE)
      begin
        pt_base <= reg_wdata_in;
      end
      if (reg_addr_in == UPPT_REG_DESC_IDX)
      begin
        desc_idx <= reg_wdata_in[6:0];
      end
    end
  end

  // done follows the end states; a start leaves the end state, so its clear goes first
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      done_flag <= 1'b0;
      busy_out <= 1'b0;
    end
    else
    begin
      busy_out <= start || (active && (state != UPPT_IDLE) && !(fetched && !phase));
      if (start)
      begin
        done_flag <= 1'b0;
      end
      else if ((state == UPPT_DONE) || (state == UPPT_FALLBACK))
      begin
        done_flag <= 1'b1;
      end
    end
  end

  assign status_word = {20'h00000, cpb_bad_b, cpb_bad_a, pt_bad, use_backup,
    fallback_out, done_flag, active, state, 2'h0};
  assign rd_mux = (reg_addr_in == UPPT_REG_CTRL) ? 32'h00000000
    : (reg_addr_in == UPPT_REG_PT_BASE) ? pt_base
    : (reg_addr_in == UPPT_REG_DESC_IDX) ? {25'h0000000, desc_idx}
    : (reg_addr_in == UPPT_REG_STATUS) ? status_word
    : (reg_addr_in == UPPT_REG_SLOT) ? {23'h000000, slot}
    : (reg_addr_in == UPPT_REG_IMG_LO) ? load_addr_out[31:0]
    : (reg_addr_in == UPPT_REG_IMG_HI) ? load_addr_out[63:32]
    : (reg_addr_in == UPPT_REG_TRIES) ? {16'h0000, tries}
    : 32'h00000000;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      reg_rdata_out <= 32'h00000000;
    end
    else
    begin
      reg_rdata_out <= reg_rd_in ? rd_mux : 32'h00000000;
    end
  end

endmodule // uppt_manager
`default_nettype wire

// >>> rtl/uppt_pkg.sv
// constants, register map and state codes of the update pointer block manager
// assumes byte-addressed flash reads of little-endian 32-bit words
//
// What this block does
// - table header: magic 0x57713427, version 0 at 0x004, entry count at 0x008
// - at most 126 descriptors of 32 bytes, first at table offset 0x020
// - descriptor: name 0x00, start offset 0x10, length 0x18, flags 0x1C
// - flag bit 0 marks system partition, bit 1 marks read-only
// - each table or pointer block copy is 4 K content plus 28 K padding
// - pointer block begins with magic 0x57789609 and header size 0x18
// - pointer block size field at 0x08 holds 4096, then a reserved word
// - slot array offset at 0x10, slot count at 0x14
// - slots are 8 bytes; last slot has highest priority
// - up to 508 slots, count taken from the header field
// - images are tried in priority order until one succeeds or all fail
// - all ones means unused, all zeros cancelled, anything else an address
// - a pointer block header is checked before the block is used
// - when no listed image loads, fallback_out is raised; no load of a fallback image is requested
package uppt_pkg;

  localparam logic [31:0] UPPT_PT_MAGIC = 32'h57713427;
  localparam logic [31:0] UPPT_PT_VERSION = 32'h00000000;
  localparam logic [31:0] UPPT_PT_MAX_DESC = 32'h0000007e;
  localparam logic [31:0] UPPT_PT_DESC0 = 32'h00000020;
  localparam int UPPT_DESC_SHIFT = 5;
  localparam logic [31:0] UPPT_DESC_START = 32'h00000010;
  localparam int UPPT_FLAG_SYSTEM = 0;
  localparam int UPPT_FLAG_RDONLY = 1;
  localparam logic [31:0] UPPT_COPY_STRIDE = 32'h00008000;

  localparam logic [31:0] UPPT_CPB_MAGIC = 32'h57789609;
  localparam logic [31:0] UPPT_CPB_HDR_SIZE = 32'h00000018;
  localparam logic [31:0] UPPT_CPB_SIZE = 32'h00001000;
  localparam logic [31:0] UPPT_CPB_MAX_SLOTS = 32'h000001fc;
  localparam int UPPT_SLOT_SHIFT = 3;

  // words fetched per step
  localparam logic [2:0] UPPT_N_PT = 3'h3;
  localparam logic [2:0] UPPT_N_DESC = 3'h4;
  localparam logic [2:0] UPPT_N_CPB = 3'h6;
  localparam logic [2:0] UPPT_N_SLOT = 3'h2;

  // register byte offsets
  localparam logic [7:0] UPPT_REG_CTRL = 8'h00;
  localparam logic [7:0] UPPT_REG_PT_BASE = 8'h04;
  localparam logic [7:0] UPPT_REG_DESC_IDX = 8'h08;
  localparam logic [7:0] UPPT_REG_STATUS = 8'h0c;
  localparam logic [7:0] UPPT_REG_SLOT = 8'h10;
  localparam logic [7:0] UPPT_REG_IMG_LO = 8'h14;
  localparam logic [7:0] UPPT_REG_IMG_HI = 8'h18;
  localparam logic [7:0] UPPT_REG_TRIES = 8'h1c;

  localparam logic [31:0] UPPT_PT_BASE_RST = 32'h00000000;
  localparam logic [6:0] UPPT_DESC_IDX_RST = 7'h04;

  typedef enum logic [2:0] {
    UPPT_IDLE = 3'b000,
    UPPT_PT_HDR = 3'b001,
    UPPT_DESC = 3'b011,
    UPPT_CPB_HDR = 3'b010,
    UPPT_SLOT = 3'b110,
    UPPT_LOAD = 3'b111,
    UPPT_DONE = 3'b101,
    UPPT_FALLBACK = 3'b100
  } uppt_state_t;

endpackage

// >>> rtl/uppt_hdr_check.sv
// header checks for the partition table and pointer block
// assumes words holds the first six little-endian header words
`timescale 1ns/1ps
`default_nettype none
module uppt_hdr_check
  import uppt_pkg::*;
(
  input wire logic [5:0][31:0] words_in,
  input wire logic [6:0] desc_idx_in,
  output logic pt_ok_out,
  output logic cpb_ok_out
);

  logic [31:0] slot_end;
  logic [31:0] idx_wide;

  assign idx_wide = {25'h0000000, desc_idx_in};
  // table header and descriptor range
  assign pt_ok_out = (words_in[0] == UPPT_PT_MAGIC) && (words_in[1] == UPPT_PT_VERSION)
    && (words_in[2] <= UPPT_PT_MAX_DESC) && (idx_wide + 32'h1 < words_in[2]);

  // slot array must fit inside the block
  assign slot_end = words_in[4] + (words_in[5] << UPPT_SLOT_SHIFT);
  assign cpb_ok_out = (words_in[0] == UPPT_CPB_MAGIC) && (words_in[1] == UPPT_CPB_HDR_SIZE)
    && (words_in[2] == UPPT_CPB_SIZE)
    && (words_in[4] >= UPPT_CPB_HDR_SIZE) && (words_in[4][2:0] == 3'h0) && (slot_end <= UPPT_CPB_SIZE)
    && (words_in[5] <= UPPT_CPB_MAX_SLOTS);

endmodule // uppt_hdr_check
`default_nettype wire

// >>> rtl/uppt_slot_class.sv
// sorts one 8-byte slot into unused, cancelled or image address
// assumes erased flash reads as all ones
`timescale 1ns/1ps
`default_nettype none
module uppt_slot_class (
  input wire logic [63:0] slot_in,
  output logic unused_out,
  output logic cancelled_out,
  output logic valid_out
);

  assign unused_out = &slot_in;
  assign cancelled_out = ~|slot_in;
  assign valid_out = !unused_out && !cancelled_out;

endmodule // uppt_slot_class
`default_nettype wire

// >>> test/uppt_manager_chk.sv
// port checker for the pointer block walker
// assumes a bind onto uppt_manager
`timescale 1ns/1ps
`default_nettype none
module uppt_manager_chk
  import uppt_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic flash_req_out,
  input wire logic [31:0] flash_addr_out,
  input wire logic flash_ack_in,
  input wire logic [31:0] flash_data_in,
  input wire logic load_req_out,
  input wire logic [63:0] load_addr_out,
  input wire logic load_done_in,
  input wire logic load_ok_in,
  input wire logic fallback_out,
  input wire logic busy_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  logic [31:0] pt_q;
  always_ff @(posedge clk_in or negedge nrst_in)
    if (!nrst_in)
      pt_q <= UPPT_PT_BASE_RST;
    else if (reg_wr_in && reg_addr_in == UPPT_REG_PT_BASE && !busy_out)
      pt_q <= reg_wdata_in;
  ////////////////////////////////////////
  sequence s_start;
    reg_wr_in && reg_addr_in == UPPT_REG_CTRL && reg_wdata_in[0] && !busy_out && !load_req_out;
  endsequence
  sequence s_win;
    load_req_out && load_done_in && load_ok_in;
  endsequence
  sequence s_fail;
    load_req_out && load_done_in && !load_ok_in;
  endsequence
  a_first_fetch: assert property (s_start |-> ##[1:2] (flash_req_out && flash_addr_out == pt_q))
    else $error("first fetch off");
  a_word_step: assert property (flash_req_out && flash_ack_in ##1 flash_req_out |->
    flash_addr_out == $past(flash_addr_out) + 32'h4) else $error("word step off");
  a_fetch_hold: assert property (flash_req_out && !flash_ack_in |=> flash_req_out && $stable(flash_addr_out))
    else $error("fetch dropped");
  a_load_addr: assert property ($rose(load_req_out) |-> load_addr_out != 64'hffffffffffffffff &&
    load_addr_out != 64'h0) else $error("bad image address");
  a_load_hold: assert property (load_req_out && !load_done_in |=> load_req_out && $stable(load_addr_out))
    else $error("load dropped");
  a_win_stop: assert property (s_win |=> (!load_req_out && !flash_req_out && !fallback_out) [*4])
    else $error("walk went on");
  a_fail_next: assert property (s_fail |-> ##[1:3] (flash_req_out || fallback_out))
    else $error("no next try");
  a_fb_excl: assert property (fallback_out |-> !load_req_out && !flash_req_out)
    else $error("fallback overlap");
  a_fb_keep: assert property ($fell(fallback_out) |-> $past(reg_wr_in) || $past(reg_wr_in, 2))
    else $error("fallback lost");
  a_rd_quiet: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
    else $error("read data stray");
endmodule // uppt_manager_chk
`default_nettype wire

// >>> test/uppt_flash_model.sv
// flash partner: sparse word store answering word fetches
// assumes the walker holds req and address until ack
`timescale 1ns/1ps
`default_nettype none
module uppt_flash_model (
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic [31:0] addr_in,
  input wire logic slow_in,
  output logic ack_out,
  output logic [31:0] data_out
);
  logic [31:0] mem [logic [31:0]];
  int wait_cnt;
  task automatic put(input logic [31:0] a, input logic [31:0] d);
    mem[a] = d;
  endtask
  task automatic erase();
    mem.delete();
  endtask
  initial
  begin
    ack_out = 1'b0;
    data_out = 32'h0;
    wait_cnt = 0;
  end
  always @(posedge clk_in)
    if (req_in && !ack_out && wait_cnt >= (slow_in ? 3 : 0))
    begin
      ack_out <= 1'b1;
      data_out <= mem.exists(addr_in) ? mem[addr_in] : 32'hffffffff;
      wait_cnt <= 0;
    end
    else
    begin
      ack_out <= 1'b0;
      data_out <= ~data_out;
      wait_cnt <= req_in ? wait_cnt + 1 : 0;
    end
endmodule // uppt_flash_model
`default_nettype wire

// >>> test/uppt_manager_tb.sv
// bench for the pointer block walker with a flash partner
// assumes the package, walker, flash model and checker
`timescale 1ns/1ps
`default_nettype none
module uppt_manager_tb;
  import uppt_pkg::*;
  logic clk_in, nrst_in, reg_wr_in, reg_rd_in, load_done_in, load_ok_in, slow;
  logic flash_req_out, flash_ack_in, load_req_out, fallback_out, busy_out;
  logic [7:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, flash_addr_out, flash_data_in, v;
  logic [63:0] load_addr_out;
  logic [63:0] seen [$];
  logic [31:0] offs [5] = '{32'h0, 32'h4, 32'h8, 32'h10, 32'h14};
  logic [31:0] bad [5] = '{32'h57789608, 32'h10, 32'h800, 32'h1c, 32'h1fd};
  logic [31:0] tbad [3] = '{32'h57713426, 32'h1, 32'h7f};
  int mismatches, checks_done, cyc;
  uppt_manager uut (.*);
  uppt_flash_model fm (.clk_in(clk_in), .req_in(flash_req_out), .addr_in(flash_addr_out), .slow_in(slow),
    .ack_out(flash_ack_in), .data_out(flash_data_in));
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  ////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input string what, input logic [63:0] s, input logic [63:0] e);
    checks_done++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
    @(posedge clk_in);
  endtask
  // start a walk and act as image loader; load number ok_at succeeds
  task automatic walk(input int ok_at);
    int k;
    int n;
    logic [31:0] st;
    k = 0;
    n = 0;
    seen.delete();
    wr(UPPT_REG_CTRL, 32'h1);
    wr(UPPT_REG_PT_BASE, 32'h0);
    rd(UPPT_REG_STATUS, st);
    chk("walk status", 64'(st & 32'h60), 64'h20);
    while (n < 600 && !(n > 2 && busy_out === 1'b0 && load_req_out === 1'b0 && flash_req_out === 1'b0))
    begin
      @(posedge clk_in);
      n++;
      if (load_req_out === 1'b1 && load_done_in === 1'b0)
      begin
        k++;
        seen.push_back(load_addr_out);
        load_ok_in <= (k == ok_at);
        load_done_in <= 1'b1;
      end
      else
        load_done_in <= 1'b0;
    end
    chk("walk end", 64'(busy_out), 64'h0);
  endtask
  task automatic expl(input int n, input logic [63:0] a0);
    chk("load count", 64'(seen.size()), 64'(n));
    if (n > 0)
      chk("first load", seen[0], a0);
  endtask
  task automatic pb(input logic [31:0] b, input logic [31:0] n);
    fm.put(b + 32'h4, UPPT_CPB_HDR_SIZE);
    fm.put(b + 32'h8, UPPT_CPB_SIZE);
    fm.put(b + 32'h10, 32'h18);
    fm.put(b + 32'h14, n);
    fm.put(b, UPPT_CPB_MAGIC);
  endtask
  task automatic layout();
    fm.erase();
    fm.put(32'h1000, UPPT_PT_MAGIC);
    fm.put(32'h1004, 32'h0);
    fm.put(32'h1008, 32'h8);
    for (int i = 0; i < 2; i++)
    begin
      fm.put(32'h10b0 + 32'(i) * 32'h20, 32'h40000 + 32'(i) * 32'h8000);
      fm.put(32'h10b4 + 32'(i) * 32'h20, 32'h0);
      fm.put(32'h10bc + 32'(i) * 32'h20, 32'h1);
    end
    fm.put(32'h40018, 32'h100000);
    fm.put(32'h4001c, 32'h0);
    fm.put(32'h40020, 32'h0);
    fm.put(32'h40024, 32'h0);
    fm.put(32'h40028, 32'h200000);
    fm.put(32'h4002c, 32'h0);
    pb(32'h40000, 32'h4);
    fm.put(32'h48018, 32'h300000);
    fm.put(32'h4801c, 32'h0);
    pb(32'h48000, 32'h1);
  endtask
  ////////////////////////////////////////
  initial
  begin
    nrst_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h0;
    reg_wdata_in = 32'h0;
    load_done_in = 1'b0;
    load_ok_in = 1'b0;
    slow = 1'b0;
    cyc = 0;
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    chk("load req", 64'(load_req_out), 64'h0);
    rd(UPPT_REG_PT_BASE, v);
    chk("pt base", 64'(v), 64'(UPPT_PT_BASE_RST));
    rd(UPPT_REG_DESC_IDX, v);
    chk("desc idx", 64'(v), 64'(UPPT_DESC_IDX_RST));
    rd(8'h20, v);
    chk("unmapped", 64'(v), 64'h0);
    rd(UPPT_REG_CTRL, v);
    chk("ctrl", 64'(v), 64'h0);
    wr(UPPT_REG_PT_BASE, 32'h1000);
    layout();
    walk(2);
    expl(2, 64'h200000);
    chk("second load", seen[1], 64'h100000);
    rd(UPPT_REG_STATUS, v);
    chk("status", 64'(v), 64'h54);
    rd(UPPT_REG_TRIES, v);
    chk("tries", 64'(v), 64'h2);
    walk(0);
    expl(2, 64'h200000);
    rd(UPPT_REG_STATUS, v);
    chk("status", 64'(v), 64'hd0);
    chk("fallback", 64'(fallback_out), 64'h1);
    for (int j = 0; j < 5; j++)
    begin
      layout();
      fm.put(32'h40000 + offs[j], bad[j]);
      slow <= j[0];
      walk(1);
      expl(1, 64'h300000);
      rd(UPPT_REG_STATUS, v);
      chk("status", 64'(v), 64'h554);
    end
    layout();
    fm.put(32'h40000, 32'h0);
    fm.put(32'h48000, 32'h0);
    walk(1);
    expl(0, 64'h0);
    rd(UPPT_REG_STATUS, v);
    chk("both bad", 64'(v & 32'hc80), 64'hc80);
    for (int j = 0; j < 3; j++)
    begin
      layout();
      fm.put(32'h1000 + 32'(j) * 32'h4, tbad[j]);
      walk(1);
      expl(0, 64'h0);
      rd(UPPT_REG_STATUS, v);
      chk("table bad", 64'(v & 32'h200), 64'h200);
      chk("fallback", 64'(fallback_out), 64'h1);
    end
    layout();
    for (int a = 0; a < 14; a++)
      fm.put(32'h40000 + 32'(a) * 32'h4, 32'hffffffff);
    fm.put(32'h40018, 32'h100000);
    fm.put(32'h4001c, 32'h0);
    fm.put(32'h40020, 32'h200000);
    fm.put(32'h40024, 32'h0);
    fm.put(32'h40028, 32'h500000);
    fm.put(32'h4002c, 32'h1);
    pb(32'h40000, 32'h4);
    walk(1);
    expl(1, 64'h100500000);
    rd(UPPT_REG_IMG_HI, v);
    chk("image hi", 64'(v), 64'h1);
    fm.put(32'h40028, 32'h0);
    fm.put(32'h4002c, 32'h0);
    walk(1);
    expl(1, 64'h200000);
    rd(UPPT_REG_IMG_LO, v);
    chk("image lo", 64'(v), 64'h200000);
    rd(UPPT_REG_SLOT, v);
    chk("slot", 64'(v), 64'h1);
    end_sim();
  end
endmodule // uppt_manager_tb
bind uppt_manager uppt_manager_chk chk (.*);
`default_nettype wire
